// [tb/msc_config_regs_tb.sv]
// self-checking bench for the system configuration register bank
`timescale 1ns/100ps
`default_nettype none
module msc_config_regs_tb;
   import msc_pkg::*;
   localparam int HU = 100;
   localparam int MSC = 10;
   logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err, st;
   logic startup_failed = 1'b0, precharge_req = 1'b0, hard_trip_pin = 1'b0;
   logic pready, pslverr, pwm_period_start, sample_strobe, two_phase_active;
   logic restart_exhausted, hard_trip_active, precharge_active;
   logic [7:0] paddr = 8'h00, mod_index = 8'h00;
   logic [7:0] hard_trip_level_pct;
   logic [8:0] dead_time_cycles;
   logic [9:0] min_on_cycles;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic [19:0] sense_fullscale_uv;
   logic [15:0] pwm_period_cycles, d;
   logic [15:0] rnd = 16'h39F2;
   logic [6:0] windmill_brake_pct;
   logic [15:0] sh [4];
   int n_mismatch = 0, total_checks = 0, n, m, e, c, p;
   int boot [8] = '{0, 1, 2, 5, 10, 20, 50, 100};
   logic [7:0] corner [8] = '{8'h80, 8'h50, 8'h40, 8'h3F, 8'h7F, 8'hFF, 8'h41, 8'h00};

   msc_config_regs #(.HOLD_UNIT_CYCLES(HU), .MS_CYCLES(MSC)) DUT (
      .clk(clk),
      .rst(rst),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .mod_index(mod_index),
      .hard_trip_pin(hard_trip_pin),
      .startup_failed(startup_failed),
      .precharge_req(precharge_req),
      .sense_fullscale_uv(sense_fullscale_uv),
      .pwm_period_cycles(pwm_period_cycles),
      .dead_time_cycles(dead_time_cycles),
      .min_on_cycles(min_on_cycles),
      .pwm_period_start(pwm_period_start),
      .sample_strobe(sample_strobe),
      .two_phase_active(two_phase_active),
      .restart_exhausted(restart_exhausted),
      .hard_trip_active(hard_trip_active),
      .hard_trip_level_pct(hard_trip_level_pct),
      .windmill_brake_pct(windmill_brake_pct),
      .precharge_active(precharge_active)
   );

   initial begin
      forever #5 clk = ~clk;
   end
   // ==========
   // expectations and bus helpers
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // codes 0 and 1 clamp to the 10-cycle floor instead of giving 0 or 5 cycles
   function automatic logic [31:0] exp_dead(input logic [5:0] code);
      return (code < 6'h02) ? 32'h0000_000A : 32'h0000_0005 * code;
   endfunction
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // a wait that runs out ends the run at once
   task automatic wait_lvl(ref logic s, input logic lvl, input int lim, output int k);
      k = 0;
      while (s !== lvl && k < lim) begin
         @(posedge clk);
         k++;
      end
      if (k >= lim) begin
         chk("wait", 1, 0);
         print_verdict();
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] v);
      int k;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0000, v};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      wait_lvl(pready, 1'b1, 20, k);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic pulse_fail(input int cnt);
      repeat (cnt) begin
         startup_failed <= 1'b1;
         @(posedge clk);
         startup_failed <= 1'b0;
         @(posedge clk);
      end
   endtask
   // decoded outputs trail the register by one cycle
   task automatic chk_out();
      repeat (2) @(posedge clk);
      chk("sense", 20'h7A120 >> sh[0][9:8], sense_fullscale_uv);
      chk("period", 16'h0BEA + 16'h0028 * sh[0][7:0], pwm_period_cycles);
      chk("dead", exp_dead(sh[1][9:4]), dead_time_cycles);
      chk("min_on", 8'h28 * sh[3][9:6], min_on_cycles);
      chk("level", sh[3][0] ? 8'hC8 : 8'h96, hard_trip_level_pct);
      chk("windmill", 7'h19 * (sh[3][2:1] + 2'h1), windmill_brake_pct);
      chk("two_phase", sh[2][9:8] == 2'b00, two_phase_active);
   endtask
   // ==========
   // main sequence
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      sh = '{16'h0000, 16'h01E0, 16'h0360, 16'h0020};
      for (n = 0; n < 20; n++) begin
         e = n % 4;
         if (n >= 4) begin
            rnd = lfsr(lfsr(rnd));
            d = rnd;
            if (e == 2 && d[9:8] == 2'b10) d[8] = 1'b1;
            apb(1'b1, 8'(e * 4), d);
            sh[e] = d & 16'h03FF;
         end
         apb(1'b0, 8'(e * 4), 16'h0000);
         chk("config word", {16'h0000, sh[e]}, rd);
         chk("read error", 0, err);
         chk_out();
      end
      apb(1'b1, OFS_DETECT, 16'h0200);
      chk("prohibited scheme error", 1, err);
      apb(1'b0, OFS_DETECT, 16'h0000);
      chk("prohibited scheme kept", {16'h0000, sh[2]}, rd);
      apb(1'b0, 8'h18, 16'h0000);
      chk("unmapped error", 1, err);
      // hysteresis: the first corner forces a known state
      apb(1'b1, OFS_DETECT, 16'h0300);
      st = 1'b0;
      for (n = 0; n < 16; n++) begin
         rnd = lfsr(rnd);
         d[7:0] = (n < 8) ? corner[n] : rnd[7:0];
         mod_index <= d[7:0];
         st = (d[7:0] >= 8'h80) ? 1'b1 : (d[7:0] < 8'h40) ? 1'b0 : st;
         repeat (3) @(posedge clk);
         chk("auto scheme", st, two_phase_active);
      end
      mod_index <= 8'h00;
      for (c = 0; c < 4; c++) begin
         apb(1'b1, OFS_DETECT, 16'h0130 | 16'(c << 6));
         apb(1'b1, OFS_CTRL, 16'h0001);
         e = (c == 3) ? 25 : 5 << c;
         pulse_fail(e - 1);
         chk("not exhausted", 0, restart_exhausted);
         pulse_fail(1);
         chk("exhausted", c != 3, restart_exhausted);
         apb(1'b0, OFS_STATUS, 16'h0000);
         chk("restart count", e, rd[8:4]);
      end
      for (c = 0; c < 4; c++) begin
         e = 200 - 50 * c;
         apb(1'b1, OFS_BASIC, 16'h01E0 | 16'(c));
         apb(1'b1, OFS_DETECT, 16'h0100 | 16'(c << 4));
         hard_trip_pin <= 1'b1;
         repeat (e - 4) @(posedge clk);
         hard_trip_pin <= 1'b0;
         repeat (10) @(posedge clk);
         chk("short trip pulse", 0, hard_trip_active);
         hard_trip_pin <= 1'b1;
         wait_lvl(hard_trip_active, 1'b1, 400, n);
         chk("trip filter", 1, n >= e && n <= e + 4);
         hard_trip_pin <= 1'b0;
         wait_lvl(hard_trip_active, 1'b0, 2000, m);
         chk("trip hold", 1, m + 1 >= (c + 1) * HU && m <= (c + 1) * HU + 1);
      end
      for (c = 0; c < 8; c++) begin
         apb(1'b1, OFS_OCP, 16'(c << 3));
         precharge_req <= 1'b1;
         @(posedge clk);
         precharge_req <= 1'b0;
         @(posedge clk);
         wait_lvl(precharge_active, 1'b0, 1200, m);
         e = boot[c] * MSC;
         chk("precharge", 1, m + 1 >= e && m <= e + 1 && (e > 0 || m == 0));
      end
      // measure one whole period after the new codes have settled
      for (n = 0; n < 3; n++) begin
         rnd = lfsr(rnd);
         c = (n == 0) ? 15 : int'(rnd[3:0]);
         e = 3050 + 40 * int'(rnd[7:4]);
         apb(1'b1, OFS_PWM_FREQ, {12'h000, rnd[7:4]});
         apb(1'b1, OFS_DETECT, 16'h0100 | 16'(c));
         wait_lvl(pwm_period_start, 1'b1, 8000, m);
         @(posedge clk);
         wait_lvl(pwm_period_start, 1'b1, 8000, m);
         @(posedge clk);
         wait_lvl(sample_strobe, 1'b1, 8000, m);
         @(posedge clk);
         wait_lvl(pwm_period_start, 1'b1, 8000, p);
         chk("sample delay", 1, m + 2 >= e / 2 + 20 * c && m <= e / 2 + 20 * c);
         chk("pwm period", e, m + p + 2);
      end
      print_verdict();
   end
endmodule
`default_nettype wire

// [verilog/msc_config_regs.sv]
// system configuration bank with pwm timing, trip, restart and precharge
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module msc_config_regs
   import msc_pkg::*;
#(
   parameter int HOLD_UNIT_CYCLES = HOLD_UNIT_CYC,
   parameter int MS_CYCLES = MS_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] mod_index,
   input wire logic hard_trip_pin,
   input wire logic startup_failed,
   input wire logic precharge_req,
   output logic [19:0] sense_fullscale_uv,
   output logic [15:0] pwm_period_cycles,
   output logic [8:0] dead_time_cycles,
   output logic [9:0] min_on_cycles,
   output logic pwm_period_start,
   output logic sample_strobe,
   output logic two_phase_active,
   output logic restart_exhausted,
   output logic hard_trip_active,
   output logic [7:0] hard_trip_level_pct,
   output logic [6:0] windmill_brake_pct,
   output logic precharge_active
);
   // =====================================================
   // apb decode
   logic [15:0] pwm_frequency_config;
   logic [15:0] basic_timing_config;
   logic [15:0] detection_timing_config;
   logic [15:0] overcurrent_timing_config;
   logic [4:0] restart_count;
   wire setup = psel & ~penable;
   wire access = psel & penable;
   wire hit_freq = (paddr == OFS_PWM_FREQ);
   wire hit_basic = (paddr == OFS_BASIC);
   wire hit_det = (paddr == OFS_DETECT);
   wire hit_ocp = (paddr == OFS_OCP);
   wire hit_stat = (paddr == OFS_STATUS);
   wire hit_ctrl = (paddr == OFS_CTRL);
   wire mapped = hit_freq | hit_basic | hit_det | hit_ocp | hit_stat | hit_ctrl;
   wire [15:0] wdata = pwdata[15:0] & CFG_MASK;
   wire [1:0] w_scheme = wdata[SCHEME_LSB +: 2];
   // the prohibited scheme never reaches the block; the write is refused whole
   wire bad_scheme = hit_det & pwrite & (w_scheme == SCH_BAD);
   wire wr = access & pwrite & mapped & ~bad_scheme;
   wire clr_restart = wr & hit_ctrl & pwdata[CLR_RESTART_BIT];
   wire [15:0] status_word = {7'h00, restart_count, precharge_active,
      restart_exhausted, two_phase_active, hard_trip_active};
   wire [15:0] rd_mux = hit_freq ? pwm_frequency_config :
      hit_basic ? basic_timing_config :
      hit_det ? detection_timing_config :
      hit_ocp ? overcurrent_timing_config :
      hit_stat ? status_word : 16'h0000;
   assign pready = 1'b1;
   assign pslverr = access & (~mapped | bad_scheme);
   // read data is caught in the setup cycle so it stands through access
   always_ff @(posedge clk) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
      end else if (setup) begin
         prdata <= {16'h0000, rd_mux};
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         pwm_frequency_config <= RST_PWM_FREQ;
         basic_timing_config <= RST_BASIC;
         detection_timing_config <= RST_DETECT;
         overcurrent_timing_config <= RST_OCP;
      end else if (wr) begin
         if (hit_freq) pwm_frequency_config <= wdata;
         if (hit_basic) basic_timing_config <= wdata;
         if (hit_det) detection_timing_config <= wdata;
         if (hit_ocp) overcurrent_timing_config <= wdata;
      end
   end
   // =====================================================
   // field decode
   wire [1:0] sense_range_sel = pwm_frequency_config[SENSE_LSB +: 2];
   wire [7:0] pwm_period_code = pwm_frequency_config[PERIOD_LSB +: 8];
   wire [5:0] dead_time_code = basic_timing_config[DEAD_LSB +: 6];
   wire [3:0] hard_trip_hold_code = basic_timing_config[HOLD_LSB +: 4];
   wire [1:0] switching_scheme_sel = detection_timing_config[SCHEME_LSB +: 2];
   wire [1:0] restart_limit_sel = detection_timing_config[RESTART_LSB +: 2];
   wire [1:0] hard_trip_filter_sel = detection_timing_config[FILT_LSB +: 2];
   wire [3:0] sample_delay_code = detection_timing_config[DELAY_LSB +: 4];
   wire [3:0] min_on_time_code = overcurrent_timing_config[MINON_LSB +: 4];
   wire [2:0] precharge_time_sel = overcurrent_timing_config[PRECH_LSB +: 3];
   wire [1:0] windmill_brake_sel = overcurrent_timing_config[WIND_LSB +: 2];
   wire hard_trip_level_sel = overcurrent_timing_config[LEVEL_LSB];
   wire [19:0] next_sense = (sense_range_sel == 2'b00) ? SENSE_UV0 :
      (sense_range_sel == 2'b01) ? SENSE_UV1 :
      (sense_range_sel == 2'b10) ? SENSE_UV2 : SENSE_UV3;
   wire [15:0] next_period = 16'(PR_BASE_CYC)
      + 16'(pwm_period_code) * 16'(PR_STEP_CYC);
   // longest dead time is 315 cycles and longest on-time 600, hence 9 and 10 bits
   wire [8:0] dt_raw = 9'(dead_time_code) * 9'(DT_STEP_CYC);
   wire [8:0] next_dead = (dt_raw < 9'(DT_MIN_CYC)) ? 9'(DT_MIN_CYC) : dt_raw;
   wire [9:0] next_min_on = 10'(min_on_time_code) * 10'(MO_STEP_CYC);
   wire [8:0] delay_cyc = 9'(sample_delay_code) * 9'(CD_STEP_CYC);
   wire [7:0] next_level = hard_trip_level_sel ? TRIP_PCT_HI : TRIP_PCT_LO;
   wire [6:0] next_wind = 7'(windmill_brake_sel) * WIND_PCT_STEP + WIND_PCT_STEP;
   wire [7:0] filt_cyc = (hard_trip_filter_sel == 2'b00) ? 8'(FILT0_CYC) :
      (hard_trip_filter_sel == 2'b01) ? 8'(FILT1_CYC) :
      (hard_trip_filter_sel == 2'b10) ? 8'(FILT2_CYC) : 8'(FILT3_CYC);
   wire [31:0] hold_load = 32'(32'(hard_trip_hold_code) + 32'h1)
      * 32'(HOLD_UNIT_CYCLES);
   wire [31:0] prech_load = 32'(BOOT_MS[precharge_time_sel])
      * 32'(MS_CYCLES);
   wire [4:0] restart_lim = (restart_limit_sel == 2'b00) ? RESTART_LIM0 :
      (restart_limit_sel == 2'b01) ? RESTART_LIM1 : RESTART_LIM2;
   wire unlimited = (restart_limit_sel == 2'b11);
   always_ff @(posedge clk) begin
      if (rst) begin
         sense_fullscale_uv <= SENSE_UV0;
         pwm_period_cycles <= 16'(PR_BASE_CYC);
         dead_time_cycles <= 9'(DT_MIN_CYC);
         min_on_cycles <= 10'h000;
         hard_trip_level_pct <= TRIP_PCT_LO;
         windmill_brake_pct <= WIND_PCT_STEP;
      end else begin
         sense_fullscale_uv <= next_sense;
         pwm_period_cycles <= next_period;
         dead_time_cycles <= next_dead;
         min_on_cycles <= next_min_on;
         hard_trip_level_pct <= next_level;
         windmill_brake_pct <= next_wind;
      end
   end
   // =====================================================
   // pwm period counter and sampling point
   logic [15:0] pwm_cnt;
   wire pwm_wrap = (pwm_cnt >= next_period - 16'h0001);
   wire [15:0] sample_at = (next_period >> 1) + 16'(delay_cyc);
   always_ff @(posedge clk) begin
      if (rst) begin
         pwm_cnt <= 16'h0000;
         pwm_period_start <= 1'b0;
         sample_strobe <= 1'b0;
      end else begin
         pwm_cnt <= pwm_wrap ? 16'h0000 : pwm_cnt + 16'h0001;
         pwm_period_start <= pwm_wrap;
         sample_strobe <= (pwm_cnt == sample_at);
      end
   end
   // =====================================================
   // switching scheme
   msc_mod_st_t mod_st;
   msc_mod_st_t next_mod_st;
   always_comb begin
      next_mod_st = mod_st;
      case (mod_st)
         ST_THREE: begin
            if (mod_index >= MOD_HALF) next_mod_st = ST_TWO;
         end
         ST_TWO: begin
            if (mod_index < MOD_QUARTER) next_mod_st = ST_THREE;
         end
         default: begin
            next_mod_st = ST_THREE;
         end
      endcase
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         mod_st <= ST_THREE;
      end else if (switching_scheme_sel == SCH_AUTO) begin
         mod_st <= next_mod_st;
      end else begin
         mod_st <= (switching_scheme_sel == SCH_TWO) ? ST_TWO : ST_THREE;
      end
   end
   assign two_phase_active = (mod_st == ST_TWO);
   // =====================================================
   // restart limit
   wire restart_full = (restart_count == 5'h1F);
   always_ff @(posedge clk) begin
      if (rst) begin
         restart_count <= 5'h00;
      end else if (startup_failed) begin
         // a failure in the clearing cycle still counts
         restart_count <= clr_restart ? 5'h01 :
            (restart_full ? restart_count : restart_count + 5'h01);
      end else if (clr_restart) begin
         restart_count <= 5'h00;
      end
   end
   assign restart_exhausted = ~unlimited & (restart_count >= restart_lim);
   // =====================================================
   // hard trip: pin sync, filter, hold
   logic trip_s1;
   logic trip_s2;
   logic [7:0] filt_cnt;
   always_ff @(posedge clk) begin
      if (rst) begin
         trip_s1 <= 1'b0;
         trip_s2 <= 1'b0;
      end else begin
         trip_s1 <= hard_trip_pin;
         trip_s2 <= trip_s1;
      end
   end
   wire trip_fire = trip_s2 & (filt_cnt == filt_cyc - 8'h01);
   always_ff @(posedge clk) begin
      if (rst) begin
         filt_cnt <= 8'h00;
      end else if (!trip_s2) begin
         filt_cnt <= 8'h00;
      end else if (filt_cnt < filt_cyc) begin
         filt_cnt <= filt_cnt + 8'h01;
      end
   end
   msc_tmr_if hold_if ();
   msc_tmr_if prech_if ();
   assign hold_if.load = trip_fire;
   assign hold_if.count = hold_load;
   msc_timer u_hold (
      .clk(clk),
      .rst(rst),
      .t(hold_if)
   );
   assign hard_trip_active = hold_if.busy;
   // =====================================================
   // bootstrap precharge; a zero code never goes busy
   assign prech_if.load = precharge_req & ~prech_if.busy;
   assign prech_if.count = prech_load;
   msc_timer u_prech (
      .clk(clk),
      .rst(rst),
      .t(prech_if)
   );
   assign precharge_active = prech_if.busy;
   // =====================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   rsv_bits_zero_a: assert property (
      (pwm_frequency_config[15:10] | basic_timing_config[15:10]
      | detection_timing_config[15:10] | overcurrent_timing_config[15:10]) == 6'h00)
      else $error("reserved config bits not zero");
   sense_sel_a: assert property (
      $changed(sense_range_sel) |=> sense_fullscale_uv == next_sense)
      else $error("sense full scale not following range select");
   period_len_a: assert property (
      pwm_period_start && $stable(pwm_period_code)
      && $past(pwm_period_code, 2) == pwm_period_code |->
      $past(pwm_cnt) == 16'(PR_BASE_CYC) + 16'(pwm_period_code) * 16'(PR_STEP_CYC) - 16'h1)
      else $error("pwm period length wrong");
   dead_min_a: assert property (
      ##1 $stable(dead_time_code) |-> dead_time_cycles >= 9'(DT_MIN_CYC)
      && (dead_time_code < 6'h02 || dead_time_cycles == 9'(dead_time_code) * 9'(DT_STEP_CYC)))
      else $error("dead time out of step or below minimum");
   no_prohib_a: assert property (
      switching_scheme_sel != SCH_BAD)
      else $error("prohibited switching scheme stored");
   auto_two_a: assert property (
      switching_scheme_sel == SCH_AUTO && !two_phase_active && mod_index >= MOD_HALF
      |=> two_phase_active)
      else $error("auto mode missed move to two-phase");
   auto_three_a: assert property (
      switching_scheme_sel == SCH_AUTO && two_phase_active && mod_index < MOD_QUARTER
      |=> !two_phase_active)
      else $error("auto mode missed return to three-phase");
   restart_lim_a: assert property (
      restart_exhausted |-> !unlimited && restart_count >= 5'h05)
      else $error("restart limit reported wrongly");
   trip_hold_a: assert property (
      trip_fire |=> hard_trip_active && $past(hold_load) ==
      (32'(hard_trip_hold_code) + 32'h1) * 32'(HOLD_UNIT_CYCLES))
      else $error("hard trip hold not started with right length");
   trip_filter_a: assert property (
      $rose(trip_s2) |->
      !trip_fire[*8])
      else $error("hard trip passed filter too early");
   sample_pt_a: assert property (
      sample_strobe |-> $past(pwm_cnt) == $past(sample_at))
      else $error("sample strobe off the delayed midpoint");
   // =====================================================
   // decoded outputs, precharge start, restart clear, read data and trip re-arm against the rules
   sense_val_a: assert property (
      ##1 $stable(sense_range_sel)
      |-> sense_fullscale_uv == (SENSE_UV0 >> sense_range_sel))
      else $error("sense full scale wrong for range code");
   period_out_a: assert property (
      ##1 $stable(pwm_period_code) |-> pwm_period_cycles
      == 16'(PR_BASE_CYC) + 16'(pwm_period_code) * 16'(PR_STEP_CYC))
      else $error("pwm period output wrong for code");
   min_on_a: assert property (
      ##1 $stable(min_on_time_code)
      |-> min_on_cycles == 10'(min_on_time_code) * 10'(MO_STEP_CYC))
      else $error("minimum on-time wrong for code");
   level_pct_a: assert property (
      ##1 $stable(hard_trip_level_sel)
      |-> hard_trip_level_pct == (hard_trip_level_sel ? TRIP_PCT_HI : TRIP_PCT_LO))
      else $error("hard trip level wrong for select");
   wind_pct_a: assert property (
      ##1 $stable(windmill_brake_sel)
      |-> windmill_brake_pct == 7'(windmill_brake_sel) * WIND_PCT_STEP + WIND_PCT_STEP)
      else $error("windmill brake share wrong for select");
   prech_start_a: assert property (
      prech_if.load
      |=> precharge_active == ($past(precharge_time_sel) != 3'h0))
      else $error("precharge start wrong for its code");
   restart_clr_a: assert property (
      clr_restart && !startup_failed
      |=> restart_count == 5'h00)
      else $error("restart count not cleared");
   fixed_scheme_a: assert property (
      switching_scheme_sel != SCH_AUTO
      |=> two_phase_active == ($past(switching_scheme_sel) == SCH_TWO))
      else $error("fixed switching scheme not followed");
   rd_high_zero_a: assert property (
      access
      |-> prdata[31:10] == 22'h0)
      else $error("read data has bits set above the fields");
   trip_rearm_a: assert property (
      !trip_s2
      |=> !trip_fire)
      else $error("hard trip fired without a held pin");
   cov_trip_c: cover property (trip_fire ##1 hard_trip_active);
   cov_auto_c: cover property (switching_scheme_sel == SCH_AUTO ##1 two_phase_active);
   cov_exh_c: cover property ($rose(restart_exhausted));
   cov_prech_c: cover property ($rose(precharge_active));
   cov_fixed_c: cover property (switching_scheme_sel == SCH_TWO ##1 two_phase_active);
endmodule
`default_nettype wire

// [verilog/msc_pkg.sv]
// package: offsets, fields, reset values and timing of the config bank
package msc_pkg;
   // =====================================================
   // clock and register map
   localparam int CLK_MHZ = 100;
   localparam logic [7:0] OFS_PWM_FREQ = 8'h00;
   localparam logic [7:0] OFS_BASIC = 8'h04;
   localparam logic [7:0] OFS_DETECT = 8'h08;
   localparam logic [7:0] OFS_OCP = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_CTRL = 8'h14;
   localparam logic [15:0] CFG_MASK = 16'h03FF;
   // =====================================================
   // field positions
   localparam int SENSE_LSB = 8;
   localparam int PERIOD_LSB = 0;
   localparam int DEAD_LSB = 4;
   localparam int HOLD_LSB = 0;
   localparam int SCHEME_LSB = 8;
   localparam int RESTART_LSB = 6;
   localparam int FILT_LSB = 4;
   localparam int DELAY_LSB = 0;
   localparam int MINON_LSB = 6;
   localparam int PRECH_LSB = 3;
   localparam int WIND_LSB = 1;
   localparam int LEVEL_LSB = 0;
   localparam int CLR_RESTART_BIT = 0;
   // =====================================================
   // reset values
   localparam logic [15:0] RST_PWM_FREQ = 16'h0000;
   localparam logic [15:0] RST_BASIC = 16'h01E0;
   localparam logic [15:0] RST_DETECT = 16'h0360;
   localparam logic [15:0] RST_OCP = 16'h0020;
   // =====================================================
   // times in their own units, then cycles
   localparam int PR_BASE_NS = 30500;
   localparam int PR_STEP_NS = 400;
   localparam int DT_STEP_NS = 50;
   localparam int DT_MIN_NS = 100;
   localparam int CD_STEP_NS = 200;
   localparam int MO_STEP_NS = 400;
   localparam int FILT0_NS = 2000;
   localparam int FILT1_NS = 1500;
   localparam int FILT2_NS = 1000;
   localparam int FILT3_NS = 500;
   localparam int HOLD_UNIT_MS = 100;
   localparam int BOOT_MS [8] = '{0, 1, 2, 5, 10, 20, 50, 100};
   localparam int PR_BASE_CYC = (PR_BASE_NS * CLK_MHZ + 999) / 1000;
   localparam int PR_STEP_CYC = (PR_STEP_NS * CLK_MHZ + 999) / 1000;
   localparam int DT_STEP_CYC = (DT_STEP_NS * CLK_MHZ + 999) / 1000;
   localparam int DT_MIN_CYC = (DT_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int CD_STEP_CYC = (CD_STEP_NS * CLK_MHZ + 999) / 1000;
   localparam int MO_STEP_CYC = (MO_STEP_NS * CLK_MHZ + 999) / 1000;
   localparam int FILT0_CYC = (FILT0_NS * CLK_MHZ + 999) / 1000;
   localparam int FILT1_CYC = (FILT1_NS * CLK_MHZ + 999) / 1000;
   localparam int FILT2_CYC = (FILT2_NS * CLK_MHZ + 999) / 1000;
   localparam int FILT3_CYC = (FILT3_NS * CLK_MHZ + 999) / 1000;
   localparam int HOLD_UNIT_CYC = HOLD_UNIT_MS * CLK_MHZ * 1000;
   localparam int MS_CYC = CLK_MHZ * 1000;
   // =====================================================
   // decoded values
   localparam logic [19:0] SENSE_UV0 = 20'h7A120;
   localparam logic [19:0] SENSE_UV1 = 20'h3D090;
   localparam logic [19:0] SENSE_UV2 = 20'h1E848;
   localparam logic [19:0] SENSE_UV3 = 20'h0F424;
   localparam logic [7:0] MOD_HALF = 8'h80;
   localparam logic [7:0] MOD_QUARTER = 8'h40;
   localparam logic [4:0] RESTART_LIM0 = 5'h05;
   localparam logic [4:0] RESTART_LIM1 = 5'h0A;
   localparam logic [4:0] RESTART_LIM2 = 5'h14;
   localparam logic [7:0] TRIP_PCT_LO = 8'h96;
   localparam logic [7:0] TRIP_PCT_HI = 8'hC8;
   localparam logic [6:0] WIND_PCT_STEP = 7'h19;
   // =====================================================
   // modes and states
   typedef enum logic [1:0] {
      SCH_TWO = 2'b00,
      SCH_THREE = 2'b01,
      SCH_BAD = 2'b10,
      SCH_AUTO = 2'b11
   } msc_scheme_t;
   typedef enum logic [1:0] {
      ST_THREE = 2'b01,
      ST_TWO = 2'b10
   } msc_mod_st_t;
endpackage

// [verilog/msc_timer.sv]
// countdown timer: busy for the loaded number of cycles
`timescale 1ns/100ps
`default_nettype none
module msc_timer
   import msc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   msc_tmr_if.tmr t
);
   logic [31:0] cnt;
   // a reload while busy restarts the full count
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt <= 32'h0000_0000;
      end else if (t.load) begin
         cnt <= t.count;
      end else if (cnt != 32'h0000_0000) begin
         cnt <= cnt - 32'h0000_0001;
      end
   end
   assign t.busy = (cnt != 32'h0000_0000);
endmodule
`default_nettype wire

// [verilog/msc_tmr_if.sv]
// interface: load and busy between the bank and a countdown timer
`timescale 1ns/100ps
`default_nettype none
interface msc_tmr_if;
   logic load;
   logic [31:0] count;
   logic busy;
   modport ctl (output load, output count, input busy);
   modport tmr (input load, input count, output busy);
endinterface
`default_nettype wire
